// ### include/lsr_params.svh
// offsets, field positions, reset values and timing counts of the light sensor register set
`ifndef LSR_PARAMS_SVH
`define LSR_PARAMS_SVH

// ==========================================================
// register offsets (one byte each)
`define LSR_ADDR_OPMODE 8'h00
`define LSR_ADDR_CTRL   8'h01
`define LSR_ADDR_RES_LO 8'h02
`define LSR_ADDR_RES_HI 8'h03
`define LSR_ADDR_ID     8'h0F
`define LSR_ADDR_LAST   8'h0F

// ==========================================================
// field positions
`define LSR_OPM_LSB     5
`define LSR_RANGE_LSB   0
`define LSR_RES_LSB     2
`define LSR_ID_LSB      3
`define LSR_BROWNOUT_BIT 7

// ==========================================================
// reset values
`define LSR_CTRL_RST    8'h00
`define LSR_RESULT_RST  16'h0000
`define LSR_BROWNOUT_RST 1'b1

// ==========================================================
// full scale illuminance per range code, in lux
`define LSR_FULL_SCALE_0 16'h03E8
`define LSR_FULL_SCALE_1 16'h0FA0
`define LSR_FULL_SCALE_2 16'h3E80
`define LSR_FULL_SCALE_3 16'hFA00

// ==========================================================
// valid result bits per resolution code
`define LSR_MASK_16     16'hFFFF
`define LSR_MASK_12     16'h0FFF
`define LSR_MASK_8      16'h00FF
`define LSR_MASK_4      16'h000F

// ==========================================================
// integration times in ns, and the clock period they are counted in
`define LSR_CLK_PERIOD_NS 4
`define LSR_T_INT4_NS   22000
`define LSR_T_INT8_NS   352000
`define LSR_T_INT12_NS  5600000
`define LSR_T_INT16_NS  105000000
`define LSR_INT4_CYC    (`LSR_T_INT4_NS / `LSR_CLK_PERIOD_NS)
`define LSR_INT8_CYC    (`LSR_T_INT8_NS / `LSR_CLK_PERIOD_NS)
`define LSR_INT12_CYC   (`LSR_T_INT12_NS / `LSR_CLK_PERIOD_NS)
`define LSR_INT16_CYC   (`LSR_T_INT16_NS / `LSR_CLK_PERIOD_NS)

`endif

// ### include/lsr_pkg.sv
// types shared by the light sensor register set
package lsr_pkg;

  // ==========================================================
  // serial target states
  typedef enum logic [3:0] {
    LSR_ST_IDLE,
    LSR_ST_ADDR,
    LSR_ST_ACK_ADDR,
    LSR_ST_REG,
    LSR_ST_ACK_REG,
    LSR_ST_WR,
    LSR_ST_ACK_WR,
    LSR_ST_RD,
    LSR_ST_ACK_RD
  } lsr_i2c_st_t;

  // ==========================================================
  // converter control as seen by the analog side
  typedef struct packed {
    logic [2:0] op_mode;
    logic [1:0] resolution_sel;
    logic [1:0] lux_scale_sel;
  } lsr_ctrl_t;

endpackage

// ### src/lsr_conv_timer.sv
// integration period counter of the light sensor converter
`timescale 1ns/10ps
`include "lsr_params.svh"

module lsr_conv_timer #(
  parameter int CYC4  = `LSR_INT4_CYC,
  parameter int CYC8  = `LSR_INT8_CYC,
  parameter int CYC12 = `LSR_INT12_CYC,
  parameter int CYC16 = `LSR_INT16_CYC,
  parameter int CNT_W = 32
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       restart,
  input  wire logic       run,
  input  wire logic [1:0] res_sel,
  output logic            done
);

  // ==========================================================
  // parameter check
  generate
    if (CNT_W < 2 || CNT_W > 32 || CYC4 < 1 || CYC8 < 1 || CYC12 < 1 || CYC16 < 1 ||
        (CNT_W < 31 && (CYC16 >= (1 << CNT_W) || CYC12 >= (1 << CNT_W))))
    begin : g_bad_param
      $error("lsr_conv_timer: counts do not fit the counter");
    end
  endgenerate

  localparam logic [CNT_W-1:0] LIM4  = CNT_W'(CYC4);
  localparam logic [CNT_W-1:0] LIM8  = CNT_W'(CYC8);
  localparam logic [CNT_W-1:0] LIM12 = CNT_W'(CYC12);
  localparam logic [CNT_W-1:0] LIM16 = CNT_W'(CYC16);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] limit;
  logic             done_reg;

  // ==========================================================
  // period follows the resolution code: more bits, longer integration
  always_comb
  begin
    case (res_sel)
      2'h0:    limit = LIM16; // R3
      2'h1:    limit = LIM12;
      2'h2:    limit = LIM8;
      default: limit = LIM4;
    endcase
  end

  // counter restarts on any control change so a result never mixes settings
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end
    else if (ce)
    begin
      done_reg <= 1'b0;
      if (restart || !run)
        cnt_reg <= '0;
      else if (cnt_reg >= limit - CNT_W'(1))
      begin
        cnt_reg  <= '0;
        done_reg <= 1'b1; // R3
      end
      else
        cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  assign done = done_reg;

  conv_len_a: // [R3]
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      ce && run && !restart && cnt_reg == limit - CNT_W'(1) |=> done_reg && cnt_reg == '0)
    else $error("conversion did not end at the selected period");

endmodule

// ### src/lsr_light_regs.sv
// register set and serial target of the ambient light sensor
`timescale 1ns/10ps
`include "lsr_params.svh"

// Overview of operation
// [R1] range code 0..3 selects 1,000, 4,000, 16,000 or 64,000 lux full scale
// [R2] resolution code selects 65,536, 4,096, 256 or 16 result codes: 16/12/8/4 bits
// [R3] integration period follows resolution: 0.022, 0.352, 5.6 or 105 ms
// [R4] control register holds range in bits 1:0, resolution in 3:2, rest reserved
// [R5] control and result registers load zero at power-on
// [R6] result low byte sits at 0x02, high byte at 0x03, both read-only
// [R7] result is right-aligned from bit 0 for every resolution
// [R8] both result bytes are overwritten at the end of each conversion
// [R9] read-only three-bit identity code in bits 5:3 of register 0x0F
// [R10] host masks bits 0-2, 6 and 7 when identifying the part
// [R11] brownout flag in bit 7 of 0x0F is set at power-up
// [R12] host writes 0 to brownout flag; it stays clear until next power-up
// [R13] host picks 16-bit resolution when mains flicker must be rejected
// [R14] mode field bits 7:5 of 0x00: off, once/continuous visible or infrared
// [R15] each written byte is acknowledged, pointer advances and wraps after last
// [R16] result bits above the selected width read as zero
module lsr_light_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h44,
  parameter logic [2:0] ID_CODE  = 3'h2,  // arbitrary value
  parameter int         CYC4     = `LSR_INT4_CYC,
  parameter int         CYC8     = `LSR_INT8_CYC,
  parameter int         CYC12    = `LSR_INT12_CYC,
  parameter int         CYC16    = `LSR_INT16_CYC
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  wire logic          scl_in,
  input  wire logic          sda_in,
  input  wire logic [15:0]   adc_raw,
  output logic               sda_out,
  output logic               sda_oe_n,
  output lsr_pkg::lsr_ctrl_t ctrl,
  output logic               conv_active,
  output logic               conv_ir,
  output logic [15:0]        full_scale_lux
);

  lsr_pkg::lsr_i2c_st_t st_reg;
  lsr_pkg::lsr_ctrl_t   ctrl_reg;
  logic                 scl_d_reg;
  logic                 sda_d_reg;
  logic [3:0]           cnt_reg;
  logic [7:0]           shift_reg;
  logic                 rnw_reg;
  logic                 sda_oe_n_reg;
  logic                 sda_out_reg;
  logic [7:0]           ptr_reg;
  logic [7:0]           ptr_next;
  logic                 brownout_flag_reg;
  logic [15:0]          result_reg;
  logic [15:0]          full_scale_lux_reg;
  logic                 conv_active_reg;
  logic                 conv_ir_reg;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 bus_start;
  logic                 bus_stop;
  logic                 wr_fire;
  logic                 rd_load;
  logic                 ptr_load;
  logic                 restart;
  logic                 run;
  logic                 conv_done;
  logic                 mode_once;
  logic [7:0]           rd_byte;
  logic [15:0]          res_mask;

  // ==========================================================
  // bus line sampling; pins are synchronous to clk_sys so one stage suffices
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else if (ce)
    begin
      scl_d_reg <= scl_in;
      sda_d_reg <= sda_in;
    end
  end

  // edge and condition detection
  assign scl_rise  = ce && scl_in && !scl_d_reg;
  assign scl_fall  = ce && !scl_in && scl_d_reg;
  assign bus_start = ce && scl_in && scl_d_reg && sda_d_reg && !sda_in;
  assign bus_stop  = ce && scl_in && scl_d_reg && !sda_d_reg && sda_in;

  // byte-complete strobes: pointer and write on the falling clock edge after the eighth bit, read load on the one ending the acknowledge
  assign ptr_load = scl_fall && st_reg == lsr_pkg::LSR_ST_REG && cnt_reg == 4'h8;
  assign wr_fire  = scl_fall && st_reg == lsr_pkg::LSR_ST_WR && cnt_reg == 4'h8;
  assign rd_load  = scl_fall && ((st_reg == lsr_pkg::LSR_ST_ACK_ADDR && rnw_reg) ||
                                 st_reg == lsr_pkg::LSR_ST_ACK_RD);

  // ==========================================================
  // serial target state machine
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg       <= lsr_pkg::LSR_ST_IDLE;
      cnt_reg      <= 4'h0;
      shift_reg    <= 8'h00;
      rnw_reg      <= 1'b0;
      sda_oe_n_reg <= 1'b1;
    end
    else if (bus_start)
    begin
      st_reg       <= lsr_pkg::LSR_ST_ADDR;
      cnt_reg      <= 4'h0;
      sda_oe_n_reg <= 1'b1;
    end
    else if (bus_stop)
    begin
      st_reg       <= lsr_pkg::LSR_ST_IDLE;
      sda_oe_n_reg <= 1'b1;
    end
    else if (scl_rise)
    begin
      case (st_reg)
        lsr_pkg::LSR_ST_ADDR, lsr_pkg::LSR_ST_REG, lsr_pkg::LSR_ST_WR:
          if (cnt_reg != 4'h8)
          begin
            shift_reg <= {shift_reg[6:0], sda_in};
            cnt_reg   <= cnt_reg + 4'h1;
          end
        lsr_pkg::LSR_ST_ACK_RD:
          if (sda_in)
            st_reg <= lsr_pkg::LSR_ST_IDLE; // host did not acknowledge: read ends
        default:
          ;
      endcase
    end
    else if (rd_load)
    begin
      // first bit goes out now, the rest on the following falling edges
      sda_oe_n_reg <= rd_byte[7];
      shift_reg    <= {rd_byte[6:0], 1'b0};
      cnt_reg      <= 4'h1;
      st_reg       <= lsr_pkg::LSR_ST_RD;
    end
    else if (scl_fall)
    begin
      case (st_reg)
        lsr_pkg::LSR_ST_ADDR:
          if (cnt_reg == 4'h8)
          begin
            if (shift_reg[7:1] == DEV_ADDR)
            begin
              sda_oe_n_reg <= 1'b0;
              rnw_reg      <= shift_reg[0];
              st_reg       <= lsr_pkg::LSR_ST_ACK_ADDR;
            end
            else
              st_reg <= lsr_pkg::LSR_ST_IDLE;
          end
        lsr_pkg::LSR_ST_REG:
          if (cnt_reg == 4'h8)
          begin
            sda_oe_n_reg <= 1'b0;
            st_reg       <= lsr_pkg::LSR_ST_ACK_REG;
          end
        lsr_pkg::LSR_ST_WR:
          if (cnt_reg == 4'h8)
          begin
            sda_oe_n_reg <= 1'b0; // R15
            st_reg       <= lsr_pkg::LSR_ST_ACK_WR;
          end
        lsr_pkg::LSR_ST_ACK_ADDR:
        begin
          sda_oe_n_reg <= 1'b1;
          cnt_reg      <= 4'h0;
          st_reg       <= lsr_pkg::LSR_ST_REG;
        end
        lsr_pkg::LSR_ST_ACK_REG, lsr_pkg::LSR_ST_ACK_WR:
        begin
          sda_oe_n_reg <= 1'b1;
          cnt_reg      <= 4'h0;
          st_reg       <= lsr_pkg::LSR_ST_WR;
        end
        lsr_pkg::LSR_ST_RD:
          if (cnt_reg == 4'h8)
          begin
            sda_oe_n_reg <= 1'b1; // release for the host acknowledge
            st_reg       <= lsr_pkg::LSR_ST_ACK_RD;
          end
          else
          begin
            sda_oe_n_reg <= shift_reg[7];
            shift_reg    <= {shift_reg[6:0], 1'b0};
            cnt_reg      <= cnt_reg + 4'h1;
          end
        default:
          ;
      endcase
    end
  end

  // line is only ever pulled low; a one is sent by releasing it
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      sda_out_reg <= 1'b0;
    else if (ce)
      sda_out_reg <= 1'b0;
  end

  // ==========================================================
  // register pointer: advances after every data byte, wraps past the last
  assign ptr_next = (ptr_reg == `LSR_ADDR_LAST) ? `LSR_ADDR_OPMODE : ptr_reg + 8'h01; // R15

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ptr_reg <= `LSR_ADDR_OPMODE;
    else if (ptr_load)
      ptr_reg <= shift_reg;
    else if (wr_fire || rd_load)
      ptr_reg <= ptr_next; // R15
  end

  // read data; unmapped offsets and reserved bits read as zero
  always_comb
  begin
    case (ptr_reg)
      `LSR_ADDR_OPMODE: rd_byte = {ctrl_reg.op_mode, 5'h00};
      `LSR_ADDR_CTRL:   rd_byte = {4'h0, ctrl_reg.resolution_sel, ctrl_reg.lux_scale_sel}; // R4
      `LSR_ADDR_RES_LO: rd_byte = result_reg[7:0];  // R6
      `LSR_ADDR_RES_HI: rd_byte = result_reg[15:8]; // R6
      `LSR_ADDR_ID:     rd_byte = {brownout_flag_reg, 1'b0, ID_CODE, 3'h0}; // R9
      default:          rd_byte = 8'h00;
    endcase
  end

  // ==========================================================
  // control registers; a host write to the mode field beats the auto power-down
  assign mode_once = ctrl_reg.op_mode == 3'h1 || ctrl_reg.op_mode == 3'h2;
  assign run       = mode_once || ctrl_reg.op_mode == 3'h5 || ctrl_reg.op_mode == 3'h6; // R14
  assign restart   = wr_fire && (ptr_reg == `LSR_ADDR_OPMODE || ptr_reg == `LSR_ADDR_CTRL);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_reg <= lsr_pkg::lsr_ctrl_t'(7'(`LSR_CTRL_RST)); // R5
    else
    begin
      if (wr_fire && ptr_reg == `LSR_ADDR_CTRL)
      begin
        ctrl_reg.lux_scale_sel  <= shift_reg[`LSR_RANGE_LSB +: 2]; // R4
        ctrl_reg.resolution_sel <= shift_reg[`LSR_RES_LSB +: 2];   // R4
      end
      if (wr_fire && ptr_reg == `LSR_ADDR_OPMODE)
        ctrl_reg.op_mode <= shift_reg[`LSR_OPM_LSB +: 3]; // R14
      else if (ce && conv_done && mode_once)
        ctrl_reg.op_mode <= 3'h0; // R14 a range write must not keep a one-shot alive
    end
  end

  // brownout flag: only power-up sets it, so a clear cannot race a set
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      brownout_flag_reg <= `LSR_BROWNOUT_RST; // R11
    else if (wr_fire && ptr_reg == `LSR_ADDR_ID && !shift_reg[`LSR_BROWNOUT_BIT])
      brownout_flag_reg <= 1'b0; // R12
  end

  // ==========================================================
  // conversion results, right-aligned with unused upper bits forced low
  always_comb
  begin
    case (ctrl_reg.resolution_sel)
      2'h0:    res_mask = `LSR_MASK_16; // R2
      2'h1:    res_mask = `LSR_MASK_12;
      2'h2:    res_mask = `LSR_MASK_8;
      default: res_mask = `LSR_MASK_4;
    endcase
  end

  lsr_conv_timer #(
    .CYC4  (CYC4),
    .CYC8  (CYC8),
    .CYC12 (CYC12),
    .CYC16 (CYC16),
    .CNT_W (32)
  ) u_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ce      (ce),
    .restart (restart),
    .run     (run),
    .res_sel (ctrl_reg.resolution_sel),
    .done    (conv_done)
  );

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      result_reg <= `LSR_RESULT_RST; // R5
    else if (ce && conv_done)
      result_reg <= adc_raw & res_mask; // R7 R8 R16
  end

  // analog-facing status and full scale, registered so outputs come from flops
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      full_scale_lux_reg <= `LSR_FULL_SCALE_0;
      conv_active_reg    <= 1'b0;
      conv_ir_reg        <= 1'b0;
    end
    else if (ce)
    begin
      case (ctrl_reg.lux_scale_sel)
        2'h0:    full_scale_lux_reg <= `LSR_FULL_SCALE_0; // R1
        2'h1:    full_scale_lux_reg <= `LSR_FULL_SCALE_1;
        2'h2:    full_scale_lux_reg <= `LSR_FULL_SCALE_2;
        default: full_scale_lux_reg <= `LSR_FULL_SCALE_3;
      endcase
      conv_active_reg <= run;
      conv_ir_reg     <= run && ctrl_reg.op_mode[1]; // R14
    end
  end

  assign sda_out        = sda_out_reg;
  assign sda_oe_n       = sda_oe_n_reg;
  assign ctrl           = ctrl_reg;
  assign conv_active    = conv_active_reg;
  assign conv_ir        = conv_ir_reg;
  assign full_scale_lux = full_scale_lux_reg;

  // ==========================================================
  // checks
  lux_map_a: // [R1]
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      ce && ctrl_reg.lux_scale_sel == 2'h3 |=> full_scale_lux_reg == 16'hFA00)
    else $error("full scale does not follow range code 3");

  result_mask_a: // [R16]
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      ce && conv_done && ctrl_reg.resolution_sel == 2'h3 |=> result_reg[15:4] == 12'h000)
    else $error("upper result bits not zero at 4-bit resolution");

  result_update_a: // [R8]
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      ce && conv_done |=> result_reg == ($past(adc_raw) & $past(res_mask)))
    else $error("result not refreshed at end of conversion");

  brownout_flag_clear_a: // [R12]
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_fire && ptr_reg == 8'h0F && !shift_reg[7] |=> !brownout_flag_reg)
    else $error("brownout flag not cleared by write");

  brownout_flag_sticky_a: // [R12]
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      !brownout_flag_reg |=> !brownout_flag_reg)
    else $error("brownout flag came back without power-up");

  ptr_wrap_a: // [R15]
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_fire && ptr_reg == 8'h0F |=> ptr_reg == 8'h00)
    else $error("pointer did not wrap after last register");

  byte_ack_a: // [R15]
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_fire |=> !sda_oe_n_reg && st_reg == lsr_pkg::LSR_ST_ACK_WR)
    else $error("written byte not acknowledged");

  once_stop_a: // [R14]
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      ce && conv_done && ctrl_reg.op_mode == 3'h1 && !(wr_fire && ptr_reg == 8'h00)
      |=> ctrl_reg.op_mode == 3'h0)
    else $error("single conversion did not power down");

endmodule

// ### bench/lsr_host_model.sv
// serial host model that drives the sensor's two-wire target
`timescale 1ns/10ps

module lsr_host_model #(
  parameter logic [6:0] DEV = 7'h44
) (
  input  wire logic  clk_sys,
  input  wire logic  sda_w,
  output logic       scl,
  output logic       sda_drv,
  output logic [7:0] rd_data,
  output int         rd_cnt,
  output int         nack_cnt
);
  // ========
  // line phases
  // idle bus: both lines released high
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
    rd_data = 8'h00;
    rd_cnt = 0;
    nack_cnt = 0;
  end

  // each level held 4 cycles, above the 2-cycle minimum the target needs
  task automatic ph(input logic s, input logic d);
    scl <= s;
    sda_drv <= d;
    repeat (4) @(posedge clk_sys);
  endtask

  // start or repeated start: data falls while clock is high
  task automatic start();
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask

  // stop: data rises while clock is high
  task automatic stop();
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask

  // ========
  // byte transfers
  // one byte out msb first, then the target's acknowledge is sampled
  task automatic put(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      ph(1'b0, b[i]);
      ph(1'b1, b[i]);
    end
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    if (sda_w !== 1'b0)
      nack_cnt++;
  endtask

  // one byte in; last byte is refused so the target lets go
  task automatic get(input logic last);
    logic [7:0] b;
    for (int i = 7; i >= 0; i--)
    begin
      ph(1'b0, 1'b1);
      ph(1'b1, 1'b1);
      b[i] = sda_w;
    end
    rd_data <= b;
    rd_cnt <= rd_cnt + 1;
    ph(1'b0, last);
    ph(1'b1, last);
  endtask

  // pointer byte then n data bytes, lowest byte of d first
  task automatic wr(input logic [6:0] da, input logic [7:0] ra, input logic [31:0] d,
                    input int n);
    start();
    put({da, 1'b0});
    put(ra);
    for (int k = 0; k < n; k++)
      put(d[8*k +: 8]);
    stop();
  endtask

  // pointer byte, repeated start, then n bytes read in a burst
  task automatic rd(input logic [7:0] ra, input int n);
    start();
    put({DEV, 1'b0});
    put(ra);
    start();
    put({DEV, 1'b1});
    for (int k = 0; k < n; k++)
      get(k == n - 1);
    stop();
  endtask
endmodule

// ### bench/lsr_light_regs_test.sv
// self-checking bench for the light sensor register set
`timescale 1ns/10ps
`include "lsr_params.svh"

module lsr_light_regs_test;
  localparam logic [6:0]  DEV = 7'h44;
  localparam int          CYC [4] = '{80, 60, 40, 20};
  localparam logic [15:0] MSK [4] = '{16'hFFFF, 16'h0FFF, 16'h00FF, 16'h000F};
  localparam logic [15:0] SCALE [4] = '{`LSR_FULL_SCALE_0, `LSR_FULL_SCALE_1,
                                        `LSR_FULL_SCALE_2, `LSR_FULL_SCALE_3};
  logic               clk_sys = 1'b0;
  logic               rst_n;
  logic               ce;
  logic [15:0]        adc_raw;
  logic               scl;
  logic               sda_drv;
  logic               sda_out;
  logic               sda_oe_n;
  wire logic          sda_w;
  lsr_pkg::lsr_ctrl_t ctrl;
  logic               conv_active;
  logic               conv_ir;
  logic [15:0]        full_scale_lux;
  logic [7:0]         rd_data;
  int                 rd_cnt;
  int                 nack_cnt;
  int                 n_fail = 0;
  int                 comparisons = 0;
  int                 cyc = 0;
  int                 busy = 0;
  int                 busy0 = 0;
  int                 seed;
  logic [31:0]        v;
  logic [7:0]         cb;
  logic [15:0]        res;
  logic [7:0]         expq [$];

  // ========
  // clock, wire and instances
  always #2 clk_sys = ~clk_sys;
  // pulled-up data line: low if either side pulls
  assign sda_w = sda_drv & (sda_oe_n | sda_out);

  lsr_light_regs #(.ID_CODE(3'h3), .CYC4(20), .CYC8(40), .CYC12(60), .CYC16(80)) dut (
    .clk_sys        (clk_sys),
    .rst_n          (rst_n),
    .ce             (ce),
    .scl_in         (scl),
    .sda_in         (sda_w),
    .adc_raw        (adc_raw),
    .sda_out        (sda_out),
    .sda_oe_n       (sda_oe_n),
    .ctrl           (ctrl),
    .conv_active    (conv_active),
    .conv_ir        (conv_ir),
    .full_scale_lux (full_scale_lux)
  );

  lsr_host_model #(.DEV(DEV)) host (
    .clk_sys  (clk_sys),
    .sda_w    (sda_w),
    .scl      (scl),
    .sda_drv  (sda_drv),
    .rd_data  (rd_data),
    .rd_cnt   (rd_cnt),
    .nack_cnt (nack_cnt)
  );

  // ========
  // checking
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    if (n_fail == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // each byte the host reads is matched against the oldest note
  always @(rd_cnt)
  begin
    #1;
    if (expq.size() == 0)
      chk("spare read", 16'h0001, 16'h0000);
    else
      chk("read byte", {8'h00, rd_data}, {8'h00, expq.pop_front()});
  end

  // cycles spent in a one-shot mode, and the hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (ce && (ctrl.op_mode == 3'b001 || ctrl.op_mode == 3'b010))
      busy <= busy + 1;
    if (cyc == 30000)
    begin
      n_fail++;
      conclude();
    end
  end

  // ========
  // main sequence
  initial
  begin
    seed = 32'h2EB4F5E3;
    rst_n = 1'b0;
    ce = 1'b1;
    adc_raw = 16'h0000;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("ctrl", {9'h000, ctrl}, 16'h0000);
    chk("full scale", full_scale_lux, SCALE[0]);
    expq = '{8'h98, 8'h00, 8'h00, 8'h00, 8'h00};
    host.rd(8'h0F, 5);
    // a one in the flag position and the code field must not stick
    host.wr(DEV, 8'h0F, 32'h000000FF, 1);
    // clear the flag, wrap to mode, then range and resolution
    host.wr(DEV, 8'h0F, 32'h000DA000, 3);
    chk("ctrl", {9'h000, ctrl}, 16'h005D);
    chk("full scale", full_scale_lux, SCALE[1]);
    expq = '{8'h18, 8'hA0, 8'h0D};
    host.rd(8'h0F, 3);
    // continuous visible then infrared keep replacing the result
    for (int k = 0; k < 2; k++)
    begin
      v = $random(seed);
      adc_raw <= v[15:0];
      host.wr(DEV, 8'h00, {24'h0, k ? 8'hC0 : 8'hA0}, 1);
      repeat (60) @(posedge clk_sys);
      chk("active", {15'h0, conv_active}, 16'h0001);
      chk("infrared", {15'h0, conv_ir}, {15'h0, k[0]});
      res = v[15:0] & MSK[3];
      expq.push_back(res[7:0]);
      expq.push_back(res[15:8]);
      host.rd(8'h02, 2);
    end
    // reserved mode idles; result bytes ignore writes; gap reads zero
    host.wr(DEV, 8'h00, 32'h00000060, 1);
    chk("active", {15'h0, conv_active}, 16'h0000);
    host.wr(DEV, 8'h02, 32'h0000FFFF, 2);
    expq = '{res[7:0], res[15:8], 8'h00, 8'h00};
    host.rd(8'h02, 4);
    // one-shot per resolution: length, auto clear, masked result
    for (int r = 0; r < 4; r++)
    begin
      v = $random(seed);
      adc_raw <= v[15:0];
      cb = {v[23:20], r[1:0], v[25:24]};
      host.wr(DEV, 8'h01, {24'h0, cb}, 1);
      busy0 = busy;
      host.wr(DEV, 8'h00, {24'h0, r[0] ? 8'h40 : 8'h20}, 1);
      // a low clock enable must hold the running count and the mode
      if (r == 0)
      begin
        ce <= 1'b0;
        repeat (100) @(posedge clk_sys);
        chk("frozen mode", {13'h0, ctrl.op_mode}, 16'h0001);
        ce <= 1'b1;
      end
      for (int w = 0; w < 300 && ctrl.op_mode != 3'b000; w++)
        @(posedge clk_sys);
      busy0 = busy - busy0;
      chk("conv time", {15'h0, busy0 >= CYC[r] - 3 && busy0 <= CYC[r] + 3}, 16'h0001);
      chk("mode clear", {13'h0, ctrl.op_mode}, 16'h0000);
      chk("full scale", full_scale_lux, SCALE[cb[1:0]]);
      res = v[15:0] & MSK[r];
      expq = '{{4'h0, cb[3:0]}, res[7:0], res[15:8]};
      host.rd(8'h01, 3);
    end
    // foreign address: address and pointer bytes both go unanswered
    host.wr(7'h45, 8'h01, 32'h0, 0);
    chk("nacks", 16'(nack_cnt), 16'h0002);
    // a new power-up sets the flag again
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    expq = '{8'h98};
    host.rd(8'h0F, 1);
    repeat (10) @(posedge clk_sys);
    chk("notes left", 16'(expq.size()), 16'h0000);
    conclude();
  end
endmodule
